/* logic/amsq_pkg.sv */
package amsq_pkg;

	localparam int CLK_HZ           = 50_000_000;
	localparam int CYC_PER_US       = CLK_HZ / 1_000_000;

	// Times as printed
	localparam int SETTLE_LONG_US   = 3000;
	localparam int SETTLE_SHORT_US  = 450;
	localparam int INTEG_FAST_US    = 250;
	localparam int INTEG_60_NS      = 16_667_000;
	localparam int INTEG_50_US      = 20_000;
	localparam int OPEN_TIE_US      = 50;
	localparam int SETTLE_UNIT_US   = 50;
	localparam int SCAN_MS          = 10;
	localparam int CONV_PER_S       = 1500;

	// Cycle counts
	localparam int SETTLE_LONG_CYC  = SETTLE_LONG_US * CYC_PER_US;
	localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_US * CYC_PER_US;
	localparam int INTEG_FAST_CYC   = INTEG_FAST_US * CYC_PER_US;
	localparam int INTEG_60_CYC     = INTEG_60_NS / 1000 * CYC_PER_US + INTEG_60_NS % 1000 * CYC_PER_US / 1000;
	localparam int INTEG_50_CYC     = INTEG_50_US * CYC_PER_US;
	localparam int OPEN_TIE_CYC     = OPEN_TIE_US * CYC_PER_US;
	localparam int SETTLE_UNIT_CYC  = SETTLE_UNIT_US * CYC_PER_US;
	localparam int SCAN_CYC         = SCAN_MS * (CLK_HZ / 1000);
	localparam int CONV_MIN_CYC     = (CLK_HZ + CONV_PER_S - 1) / CONV_PER_S;
	localparam int FETCH_CYC        = 2;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_SCHED_LEN  = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_RESULT     = 8'h0c;
	localparam logic [7:0] REG_BG_OFS     = 8'h10;
	localparam logic [7:0] REG_SCHED_BASE = 8'h40;

	localparam int CTRL_RUN      = 0;
	localparam int CTRL_CLR_OVR  = 1;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_OVERRUN  = 1;
	localparam int STAT_IDX      = 8;
	localparam int RES_NAN       = 16;

	// Instruction word fields
	localparam int F_CHAN   = 0;
	localparam int F_SE     = 5;
	localparam int F_RNG    = 6;
	localparam int F_OD     = 9;
	localparam int F_INTEG  = 10;
	localparam int F_EXREV  = 12;
	localparam int F_INREV  = 13;
	localparam int F_MOFS   = 14;
	localparam int F_REPS   = 16;
	localparam int F_SETTLE = 24;

	// Range codes: 20, 50, 200, 1000, 5000 mV, auto
	localparam logic [2:0] RNG_20   = 3'h0;
	localparam logic [2:0] RNG_50   = 3'h1;
	localparam logic [2:0] RNG_200  = 3'h2;
	localparam logic [2:0] RNG_1000 = 3'h3;
	localparam logic [2:0] RNG_5000 = 3'h4;
	localparam logic [2:0] RNG_AUTO = 3'h5;

	localparam logic [1:0] INTEG_FAST = 2'h0;
	localparam logic [1:0] INTEG_60   = 2'h1;
	localparam logic [1:0] INTEG_50   = 2'h2;

	// Offset-binary code; full scale spans 60000 of 65536 codes
	localparam logic [16:0] CODE_MID = 17'h08000;
	localparam logic [16:0] FS_HALF  = 17'h07530;
	// 90% of each range below 5000 mV expressed in 5000 mV range codes (6 codes/mV)
	localparam logic [16:0] AR_LIM_20   = 17'h0006c;
	localparam logic [16:0] AR_LIM_50   = 17'h0010e;
	localparam logic [16:0] AR_LIM_200  = 17'h00438;
	localparam logic [16:0] AR_LIM_1000 = 17'h01518;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_FETCH  = 4'h1,
		S_SETUP  = 4'h3,
		S_TIE    = 4'h2,
		S_SETTLE = 4'h6,
		S_INTEG  = 4'h7,
		S_CONV   = 4'h5,
		S_NEXT   = 4'h4,
		S_OUT    = 4'hc
	} amsq_state_e;

endpackage : amsq_pkg

/* logic/amsq_mem_if.sv */
`timescale 1ns/1ps
interface amsq_mem_if #(parameter int W = 32, parameter int AW = 4);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [W-1:0]  wr_data;
	logic [AW-1:0] rd_addr;
	logic [W-1:0]  rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : amsq_mem_if

/* logic/amsq_sched_mem.sv */
`timescale 1ns/1ps
module amsq_sched_mem #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	amsq_mem_if.mem  port
);
	logic [W-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
		port.rd_data <= mem_q[port.rd_addr];
	end
endmodule : amsq_sched_mem

/* logic/amsq_sequencer.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module amsq_sequencer #(
	parameter int DEPTH            = 16,
	parameter int SETTLE_LONG_CYC  = amsq_pkg::SETTLE_LONG_CYC,
	parameter int SETTLE_SHORT_CYC = amsq_pkg::SETTLE_SHORT_CYC,
	parameter int INTEG_FAST_CYC   = amsq_pkg::INTEG_FAST_CYC,
	parameter int INTEG_60_CYC     = amsq_pkg::INTEG_60_CYC,
	parameter int INTEG_50_CYC     = amsq_pkg::INTEG_50_CYC,
	parameter int SCAN_CYC         = amsq_pkg::SCAN_CYC,
	parameter int CONV_MIN_CYC     = amsq_pkg::CONV_MIN_CYC
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        adc_done_pin,
	input  wire logic [15:0] adc_code,
	output logic             adc_start,
	output logic      [4:0]  fe_channel,
	output logic             fe_single_ended,
	output logic      [2:0]  fe_range,
	output logic      [1:0]  fe_integ_sel,
	output logic             fe_exc_neg,
	output logic             fe_input_swap,
	output logic             fe_ground_short,
	output logic             fe_open_tie,
	output logic             fe_integrate,
	output logic             scan_tick,
	output logic             result_valid,
	output logic      [15:0] result_value,
	output logic             not_a_number_result
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = 20;

	if (DEPTH < 2 || DEPTH > 32 || (1 << AW) != DEPTH) begin : g_chk_depth
		$error("DEPTH must be a power of two from 2 to 32");
	end
	if (INTEG_50_CYC >= (1 << CW) || SCAN_CYC >= (1 << CW) || CONV_MIN_CYC < 1) begin : g_chk_cnt
		$error("Timing counts exceed counter width");
	end

	amsq_mem_if #(.W(32), .AW(AW)) mif ();
	amsq_sched_mem #(.W(32), .DEPTH(DEPTH)) u_mem (.clk(clk), .port(mif.mem));

	amsq_pkg::amsq_state_e state_q, state_d;
	logic [CW-1:0]        cnt_q, tgt, gap_q, scan_q;
	logic [31:0]          instr_q;
	logic [AW-1:0]        idx_q;
	logic [AW:0]          len_q;
	logic [7:0]           rep_q;
	logic [1:0]           seg_q;
	logic [2:0]           rng_q;
	logic                 ofs_ph_q, ar_ph_q, started_q, nan_q, run_q, overrun_q;
	logic signed [16:0]   ofs_val_q, bg_ofs_q;
	logic signed [18:0]   acc_q;
	logic [15:0]          code_q;
	logic [2:0]           done_s_q;
	logic                 done_lvl_q, done_rise;
	logic [31:0]          rd_mux, rdata_q;

	// Instruction fields
	wire [4:0] i_chan   = instr_q[amsq_pkg::F_CHAN +: 5];
	wire       i_se     = instr_q[amsq_pkg::F_SE];
	wire [2:0] i_rng    = instr_q[amsq_pkg::F_RNG +: 3];
	wire       i_od     = instr_q[amsq_pkg::F_OD];
	wire [1:0] i_integ  = instr_q[amsq_pkg::F_INTEG +: 2];
	wire       i_exr    = instr_q[amsq_pkg::F_EXREV];
	wire       i_inr    = instr_q[amsq_pkg::F_INREV] & ~i_se;
	wire       i_mofs   = instr_q[amsq_pkg::F_MOFS];
	wire [7:0] i_reps   = instr_q[amsq_pkg::F_REPS +: 8];
	wire [7:0] i_settle = instr_q[amsq_pkg::F_SETTLE +: 8];

	// Segment plan: excitation toggles on seg bit 0, inputs swap on the next bit, or on bit 0 when excitation does not reverse
	wire [1:0] nlog     = {1'b0, i_exr} + {1'b0, i_inr};
	wire [1:0] seg_last = 2'((3'h1 << nlog) - 3'h1);
	wire       meas_ph  = ~ofs_ph_q & ~ar_ph_q;
	wire       exc_neg  = meas_ph & i_exr & seg_q[0];
	wire       in_swap  = meas_ph & i_inr & (i_exr ? seg_q[1] : seg_q[0]);
	wire       fast     = ar_ph_q | (i_integ == amsq_pkg::INTEG_FAST);

	wire [CW-1:0] settle_cyc = (i_settle != 8'h00) ?
		CW'(i_settle * amsq_pkg::SETTLE_UNIT_CYC) :
		((i_integ == amsq_pkg::INTEG_FAST) ? CW'(SETTLE_SHORT_CYC) : CW'(SETTLE_LONG_CYC));
	wire [CW-1:0] integ_cyc  = fast ? CW'(INTEG_FAST_CYC) :
		((i_integ == amsq_pkg::INTEG_60) ? CW'(INTEG_60_CYC) : CW'(INTEG_50_CYC));
	wire [2:0]    cur_rng    = (ar_ph_q || rng_q == amsq_pkg::RNG_AUTO) ? amsq_pkg::RNG_5000 : rng_q;

	// Sample arithmetic on the 17-bit signed deviation from mid code
	wire signed [16:0] samp     = $signed({1'b0, code_q}) - $signed(amsq_pkg::CODE_MID);
	wire signed [16:0] ofs_use  = i_mofs ? ofs_val_q : bg_ofs_q;
	wire signed [16:0] corr     = i_se ? 17'(samp - ofs_use) : samp;
	wire               over     = (corr > $signed(amsq_pkg::FS_HALF)) ||
		(corr < -$signed(amsq_pkg::FS_HALF));
	wire signed [16:0] term     = (exc_neg ^ in_swap) ? 17'(-corr) : corr;
	wire signed [18:0] acc_sum  = acc_q + 19'(term);
	wire signed [18:0] avg      = acc_sum >>> nlog;
	wire        [16:0] mag      = samp[16] ? 17'(-samp) : samp;
	wire               timed_end = (cnt_q == tgt - CW'(1));
	wire               gap_ok    = (gap_q >= CW'(CONV_MIN_CYC - 1));
	wire               more_reps = (rep_q + 8'h01) < ((i_reps == 8'h00) ? 8'h01 : i_reps);
	wire [AW:0]        idx_nx    = {1'b0, idx_q} + (AW+1)'(1);

	function automatic logic [2:0] ar_pick(input logic [16:0] m, input logic od);
		logic [2:0] r;
		r = amsq_pkg::RNG_5000;
		if (m <= amsq_pkg::AR_LIM_20) begin
			r = amsq_pkg::RNG_20;
		end else if (m <= amsq_pkg::AR_LIM_50) begin
			r = amsq_pkg::RNG_50;
		end else if (m <= amsq_pkg::AR_LIM_200 || od) begin
			r = amsq_pkg::RNG_200;
		end else if (m <= amsq_pkg::AR_LIM_1000) begin
			r = amsq_pkg::RNG_1000;
		end
		return r;
	endfunction : ar_pick

	// Converter done pin: three flops, level changes once the last two agree
	assign done_rise = (done_s_q[1] == done_s_q[2]) & done_s_q[2] & ~done_lvl_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			done_s_q   <= 3'h0;
			done_lvl_q <= 1'b0;
		end else begin
			done_s_q <= {done_s_q[1:0], adc_done_pin};
			if (done_s_q[1] == done_s_q[2]) begin
				done_lvl_q <= done_s_q[2];
			end
		end
	end

	always_comb begin
		case (state_q)
			amsq_pkg::S_FETCH:  tgt = CW'(amsq_pkg::FETCH_CYC);
			amsq_pkg::S_TIE:    tgt = CW'(amsq_pkg::OPEN_TIE_CYC);
			amsq_pkg::S_SETTLE: tgt = settle_cyc;
			amsq_pkg::S_INTEG:  tgt = integ_cyc;
			default:            tgt = CW'(1);
		endcase
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			amsq_pkg::S_IDLE: begin
				if (scan_tick && run_q && len_q != '0) begin
					state_d = amsq_pkg::S_FETCH;
				end
			end
			amsq_pkg::S_FETCH: begin
				if (timed_end) begin
					state_d = amsq_pkg::S_SETUP;
				end
			end
			amsq_pkg::S_SETUP: begin
				state_d = (i_od && !ofs_ph_q && seg_q == 2'h0) ? amsq_pkg::S_TIE
					: amsq_pkg::S_SETTLE;
			end
			amsq_pkg::S_TIE: begin
				if (timed_end) begin
					state_d = amsq_pkg::S_SETTLE;
				end
			end
			amsq_pkg::S_SETTLE: begin
				if (timed_end) begin
					state_d = amsq_pkg::S_INTEG;
				end
			end
			amsq_pkg::S_INTEG: begin
				if (timed_end) begin
					state_d = amsq_pkg::S_CONV;
				end
			end
			amsq_pkg::S_CONV: begin
				if (started_q && done_rise) begin
					state_d = amsq_pkg::S_NEXT;
				end
			end
			amsq_pkg::S_NEXT: begin
				state_d = (meas_ph && seg_q == seg_last) ? amsq_pkg::S_OUT : amsq_pkg::S_SETUP;
			end
			amsq_pkg::S_OUT: begin
				if (more_reps) begin
					state_d = amsq_pkg::S_SETUP;
				end else if (idx_nx < len_q) begin
					state_d = amsq_pkg::S_FETCH;
				end else begin
					state_d = amsq_pkg::S_IDLE;
				end
			end
			default: state_d = amsq_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= amsq_pkg::S_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CW'(1);
		end
	end

	// Conversion start and spacing guard
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adc_start <= 1'b0;
			started_q <= 1'b0;
			gap_q     <= CW'(CONV_MIN_CYC);
			code_q    <= '0;
		end else begin
			adc_start <= state_q == amsq_pkg::S_CONV && !started_q && !adc_start && gap_ok;
			started_q <= (state_q == amsq_pkg::S_CONV) && (started_q || adc_start);
			if (adc_start) begin
				gap_q <= '0;
			end else if (!gap_ok) begin
				gap_q <= gap_q + CW'(1);
			end
			if (done_rise) begin
				code_q <= adc_code;
			end
		end
	end

	// Measurement datapath
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			instr_q <= '0; idx_q <= '0; rep_q <= '0; seg_q <= '0; rng_q <= '0;
			ofs_ph_q <= 1'b0; ar_ph_q <= 1'b0; ofs_val_q <= '0; acc_q <= '0; nan_q <= 1'b0;
		end else begin
			case (state_q)
				amsq_pkg::S_IDLE: idx_q <= '0;
				amsq_pkg::S_FETCH: if (timed_end) begin
					instr_q  <= mif.rd_data;
					rng_q    <= mif.rd_data[amsq_pkg::F_RNG +: 3];
					ar_ph_q  <= mif.rd_data[amsq_pkg::F_RNG +: 3] == amsq_pkg::RNG_AUTO;
					ofs_ph_q <= mif.rd_data[amsq_pkg::F_SE] & mif.rd_data[amsq_pkg::F_MOFS];
					rep_q <= '0; seg_q <= '0; acc_q <= '0; nan_q <= 1'b0;
				end
				amsq_pkg::S_NEXT: if (ofs_ph_q) begin
					ofs_val_q <= samp;
					ofs_ph_q  <= 1'b0;
				end else if (ar_ph_q) begin
					rng_q   <= ar_pick(mag, i_od);
					ar_ph_q <= 1'b0;
				end else begin
					acc_q <= acc_sum;
					nan_q <= nan_q | over;
					seg_q <= seg_q + 2'h1;
				end
				amsq_pkg::S_OUT: begin
					seg_q <= '0; acc_q <= '0; nan_q <= 1'b0;
					if (more_reps) begin
						rep_q   <= rep_q + 8'h01;
						ar_ph_q <= i_rng == amsq_pkg::RNG_AUTO;
						rng_q   <= i_rng;
					end else begin
						idx_q <= idx_q + AW'(1);
					end
				end
				default: ;
			endcase
		end
	end

	// Result is published from the last segment's accumulation
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			result_valid        <= 1'b0;
			result_value        <= '0;
			not_a_number_result <= 1'b0;
		end else begin
			result_valid <= (state_q == amsq_pkg::S_NEXT) && meas_ph && (seg_q == seg_last);
			if (state_q == amsq_pkg::S_NEXT && meas_ph && seg_q == seg_last) begin
				result_value        <= (nan_q | over) ? 16'h0000 : avg[15:0];
				not_a_number_result <= nan_q | over;
			end
		end
	end

	// Scan period tick; a tick while running and busy is an overrun
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scan_q    <= '0;
			scan_tick <= 1'b0;
		end else begin
			scan_tick <= (scan_q == CW'(SCAN_CYC - 1));
			scan_q    <= (scan_q == CW'(SCAN_CYC - 1)) ? '0 : scan_q + CW'(1);
		end
	end

	// Register port
	wire wr_ctrl  = reg_wr && reg_addr == amsq_pkg::REG_CTRL;
	wire sched_hit = reg_addr >= amsq_pkg::REG_SCHED_BASE &&
		reg_addr < amsq_pkg::REG_SCHED_BASE + 8'(4 * DEPTH) && reg_addr[1:0] == 2'h0;
	wire [7:0] sched_off = reg_addr - amsq_pkg::REG_SCHED_BASE;
	wire ovr_set  = scan_tick && run_q && state_q != amsq_pkg::S_IDLE;

	assign mif.wr_en   = reg_wr && sched_hit;
	assign mif.wr_addr = sched_off[AW+1:2];
	assign mif.wr_data = reg_wdata;
	assign mif.rd_addr = idx_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_addr == amsq_pkg::REG_CTRL) begin
			rd_mux[amsq_pkg::CTRL_RUN] = run_q;
		end else if (reg_addr == amsq_pkg::REG_SCHED_LEN) begin
			rd_mux[AW:0] = len_q;
		end else if (reg_addr == amsq_pkg::REG_STATUS) begin
			rd_mux[amsq_pkg::STAT_BUSY]    = state_q != amsq_pkg::S_IDLE;
			rd_mux[amsq_pkg::STAT_OVERRUN] = overrun_q;
			rd_mux[amsq_pkg::STAT_IDX +: AW] = idx_q;
		end else if (reg_addr == amsq_pkg::REG_RESULT) begin
			rd_mux[15:0] = result_value;
			rd_mux[amsq_pkg::RES_NAN] = not_a_number_result;
		end else if (reg_addr == amsq_pkg::REG_BG_OFS) begin
			rd_mux[15:0] = bg_ofs_q[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0; len_q <= '0; bg_ofs_q <= '0; overrun_q <= 1'b0; rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
			if (wr_ctrl) begin
				run_q <= reg_wdata[amsq_pkg::CTRL_RUN];
			end
			if (reg_wr && reg_addr == amsq_pkg::REG_SCHED_LEN) begin
				len_q <= (reg_wdata[AW:0] > (AW+1)'(DEPTH)) ? (AW+1)'(DEPTH) : reg_wdata[AW:0];
			end
			if (reg_wr && reg_addr == amsq_pkg::REG_BG_OFS) begin
				bg_ofs_q <= 17'($signed(reg_wdata[15:0]));
			end
			overrun_q <= ovr_set | (overrun_q & ~(wr_ctrl & reg_wdata[amsq_pkg::CTRL_CLR_OVR]));
		end
	end

	assign reg_rdata       = rdata_q;
	assign fe_channel      = i_chan;
	assign fe_single_ended = i_se;
	assign fe_range        = cur_rng;
	assign fe_integ_sel    = fast ? amsq_pkg::INTEG_FAST : i_integ;
	assign fe_exc_neg      = exc_neg;
	assign fe_input_swap   = in_swap;
	assign fe_ground_short = ofs_ph_q && state_q != amsq_pkg::S_IDLE;
	assign fe_open_tie     = state_q == amsq_pkg::S_TIE;
	assign fe_integrate    = state_q == amsq_pkg::S_INTEG;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	logic [CW-1:0] tie_len_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tie_len_q <= '0;
		end else begin
			tie_len_q <= fe_open_tie ? tie_len_q + CW'(1) : '0;
		end
	end

	a_conv_spacing: assert property (adc_start |-> gap_q >= CW'(CONV_MIN_CYC - 1))
		else $error("conversions closer than minimum spacing");
	a_start_pulse: assert property (adc_start |=> !adc_start ##1 !adc_start)
		else $error("conversion start longer than one cycle");
	a_tie_length: assert property ($fell(fe_open_tie) |-> tie_len_q == CW'(amsq_pkg::OPEN_TIE_CYC))
		else $error("open tie not held for exact time");
	a_probe_range: assert property (fe_integrate && ar_ph_q |-> fe_range == amsq_pkg::RNG_5000
		&& fe_integ_sel == amsq_pkg::INTEG_FAST)
		else $error("autorange probe not on widest range with fast integration");
	a_settle_first: assert property ($rose(fe_integrate) |-> $past(state_q) == amsq_pkg::S_SETTLE)
		else $error("integration began without settling");
	a_od_cap: assert property (state_q == amsq_pkg::S_CONV && i_od && i_rng == amsq_pkg::RNG_AUTO
		&& meas_ph |-> fe_range <= amsq_pkg::RNG_200)
		else $error("open detect autorange above 200 mV");
	a_result_span: assert property (result_valid && !not_a_number_result |->
		$signed(result_value) <= $signed(16'(amsq_pkg::FS_HALF))
		&& $signed(result_value) >= -$signed(16'(amsq_pkg::FS_HALF)))
		else $error("out of span result not flagged");
	a_valid_last: assert property (result_valid |-> $past(state_q) == amsq_pkg::S_NEXT
		&& state_q == amsq_pkg::S_OUT)
		else $error("result valid before all segments");
	a_scan_tick: assert property (scan_tick |=> !scan_tick [*2])
		else $error("scan tick repeated");
endmodule : amsq_sequencer

/* testbench/amsq_adc_model.sv */
`timescale 1ns/1ps
module amsq_adc_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        adc_start,
	input  wire logic        fe_input_swap,
	input  wire logic        fe_exc_neg,
	input  wire logic        fe_ground_short,
	input  wire logic [15:0] level,
	input  wire logic [15:0] ofs,
	output logic             adc_done_pin,
	output logic      [15:0] adc_code
);
	logic [3:0]  cnt_q;
	logic [15:0] val_q;
	// Bridge output follows excitation; offset does not reverse
	wire logic        flip   = fe_input_swap ^ fe_exc_neg;
	wire logic [15:0] sample = fe_ground_short ? ofs : (flip ? ofs - level : ofs + level);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 4'h0;
			val_q <= 16'h0000;
		end else begin
			if (adc_start)
				cnt_q <= 4'h1;
			else if (cnt_q == 4'hb)
				cnt_q <= 4'h0;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'h4)
				val_q <= 16'h8000 + sample;
		end
	end
	assign adc_done_pin = cnt_q >= 4'h5;
	// Released bus shows the inverse so a late capture cannot match
	assign adc_code = adc_done_pin ? val_q : ~val_q;
endmodule : amsq_adc_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic        clk, nrst, reg_wr, reg_rd, adc_done_pin, adc_start, fe_single_ended;
	logic        fe_exc_neg, fe_input_swap, fe_ground_short, fe_open_tie, fe_integrate;
	logic        scan_tick, result_valid, not_a_number_result;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] adc_code, result_value, level, ofs;
	logic [4:0]  fe_channel;
	logic [2:0]  fe_range;
	logic [1:0]  fe_integ_sel;
	logic [16:0] res;
	logic [2:0]  rng_log [0:63];
	int          fails = 0, total_checks = 0, starts = 0, ties = 0, s0, t0, i0;
	int          integs = 0, tk = 0, per = 0;

	// Mains integrations keep their real lengths; no scenario selects them
	amsq_sequencer #(.SETTLE_LONG_CYC(40), .SETTLE_SHORT_CYC(20), .INTEG_FAST_CYC(10),
		.SCAN_CYC(3000), .CONV_MIN_CYC(8)) u_dut (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_done_pin(adc_done_pin), .adc_code(adc_code), .adc_start(adc_start),
		.fe_channel(fe_channel), .fe_single_ended(fe_single_ended), .fe_range(fe_range),
		.fe_integ_sel(fe_integ_sel), .fe_exc_neg(fe_exc_neg), .fe_input_swap(fe_input_swap),
		.fe_ground_short(fe_ground_short), .fe_open_tie(fe_open_tie),
		.fe_integrate(fe_integrate), .scan_tick(scan_tick), .result_valid(result_valid),
		.result_value(result_value), .not_a_number_result(not_a_number_result));

	amsq_adc_model u_adc (.clk(clk), .nrst(nrst), .adc_start(adc_start),
		.fe_input_swap(fe_input_swap), .fe_exc_neg(fe_exc_neg),
		.fe_ground_short(fe_ground_short), .level(level), .ofs(ofs),
		.adc_done_pin(adc_done_pin), .adc_code(adc_code));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		tk <= (scan_tick === 1'b1) ? 0 : tk + 1;
		if (scan_tick === 1'b1)
			per <= tk + 1;
		if (fe_integrate === 1'b1)
			integs <= integs + 1;
		if (adc_start === 1'b1) begin
			rng_log[starts] <= fe_range;
			starts <= starts + 1;
		end
		if (fe_open_tie === 1'b1)
			ties <= ties + 1;
	end

	task finish_test;
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	function automatic logic [31:0] mk(input logic [2:0] rng, input logic [2:0] opt);
		mk = 32'h00010003;
		mk[amsq_pkg::F_RNG +: 3] = rng;
		mk[amsq_pkg::F_OD] = opt[0];
		mk[amsq_pkg::F_EXREV] = opt[1];
		mk[amsq_pkg::F_INREV] = opt[2];
	endfunction : mk

	// One instruction, one scan, then stop once its result is valid
	task run(input logic [31:0] w, input logic [15:0] lv, input logic [15:0] of);
		int i;
		s0 = starts;
		t0 = ties;
		i0 = integs;
		@(posedge clk);
		level <= lv;
		ofs <= of;
		wr(amsq_pkg::REG_SCHED_BASE, w);
		wr(amsq_pkg::REG_SCHED_LEN, 32'h1);
		wr(amsq_pkg::REG_CTRL, 32'h1);
		@(negedge clk);
		for (i = 0; i < 20000 && result_valid !== 1'b1; i++)
			@(negedge clk);
		res = {not_a_number_result, result_value};
		wr(amsq_pkg::REG_CTRL, 32'h0);
	endtask : run

	task t_regs;
		rd(amsq_pkg::REG_RESULT);
		chk("result_reset", 32'h0, d);
		wr(amsq_pkg::REG_BG_OFS, 32'h00000012);
		rd(amsq_pkg::REG_BG_OFS);
		chk("bg_ofs", 32'h00000012, d);
		rd(8'h20);
		chk("unmapped", 32'h0, d);
		rd(amsq_pkg::REG_SCHED_BASE);
		chk("sched_wo", 32'h0, d);
	endtask : t_regs

	task t_fixed;
		run(mk(amsq_pkg::RNG_200, 3'h0), 16'd1234, 16'h0);
		chk("fixed_val", 32'd1234, {15'h0, res});
		chk("fixed_conv", 32'd1, starts - s0);
		chk("fixed_integ", 32'd10, integs - i0);
		chk("fixed_integ_sel", 32'd0, {30'h0, fe_integ_sel});
		chk("fixed_chan", 32'd3, {27'h0, fe_channel});
	endtask : t_fixed

	task t_ofs;
		// Grounded pass reads the bare offset, which must drop out
		run(mk(amsq_pkg::RNG_200, 3'h0) | 32'h00004020, 16'd900, 16'd25);
		chk("ofs_val", 32'd900, {15'h0, res});
		chk("ofs_conv", 32'd2, starts - s0);
		chk("ofs_se", 32'd1, {31'h0, fe_single_ended});
		// Background offset register still holds 0x12 from the register test
		run(mk(amsq_pkg::RNG_200, 3'h0) | 32'h00000020, 16'd900, 16'h0012);
		chk("bg_val", 32'd900, {15'h0, res});
		chk("bg_conv", 32'd1, starts - s0);
	endtask : t_ofs

	task t_inrev;
		run(mk(amsq_pkg::RNG_200, 3'h4), 16'd500, 16'd40);
		chk("inrev_val", 32'd500, {15'h0, res});
		chk("inrev_conv", 32'd2, starts - s0);
	endtask : t_inrev

	task t_both;
		run(mk(amsq_pkg::RNG_1000, 3'h6), 16'd300, 16'd7);
		chk("both_val", 32'd300, {15'h0, res});
		chk("both_conv", 32'd4, starts - s0);
		chk("both_integ", 32'd40, integs - i0);
		chk("scan_period", 32'd3000, per);
	endtask : t_both

	task t_over;
		run(mk(amsq_pkg::RNG_50, 3'h0), 16'd31000, 16'h0);
		chk("over_nan", 32'h00010000, {15'h0, res});
	endtask : t_over

	task t_auto;
		// Just above the 20 mV limit must step up one range
		run(mk(amsq_pkg::RNG_AUTO, 3'h0), 16'd109, 16'h0);
		chk("auto_probe", 32'd4, {29'h0, rng_log[s0]});
		chk("auto_final", 32'd1, {29'h0, rng_log[starts - 1]});
		chk("auto_conv", 32'd2, starts - s0);
		chk("auto_val", 32'd109, {15'h0, res});
	endtask : t_auto

	task t_odauto;
		run(mk(amsq_pkg::RNG_AUTO, 3'h1), 16'd2000, 16'h0);
		chk("od_final", 32'd2, {29'h0, rng_log[starts - 1]});
		chk("od_tie", 32'd5000, ties - t0);
		// Two ties outlast one scan, so the next tick found it busy
		rd(amsq_pkg::REG_STATUS);
		chk("overrun", 32'h2, d);
		wr(amsq_pkg::REG_CTRL, 32'h2);
		rd(amsq_pkg::REG_STATUS);
		chk("overrun_clr", 32'h0, d);
	endtask : t_odauto

	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		level = 16'h0;
		ofs = 16'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_fixed();
		t_ofs();
		t_inrev();
		t_both();
		t_over();
		t_auto();
		t_odauto();
		finish_test();
	end

	// Eight runs, each at most one scan wait plus about five thousand cycles
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		finish_test();
	end
endmodule : tb_top
